// ### rtl/iref_flags.sv
/*
 * Interrupt enable and request-flag registers for eight sources, with a
 * fixed-priority pending selector and a summary status/mask interrupt.
 * Assumes peripherals give one-cycle set pulses synchronous to ref_clk_in,
 * and the core pulses irq_ack_in once when it takes the selected request.
 */
// Chosen here: the strobed register port.
`default_nettype none
// Contract
// RL1: Secondary enable bit 2 enables the third pin interrupt and resets to 0.
// RL2: Secondary enable bit 1 enables the timer-3 interrupt and resets to 0.
// RL3: Secondary enable bit 0 enables the converter interrupt and resets to 0.
// RL4: Secondary flag bit 2 holds the third pin request, reset 0.
// RL5: Secondary flag bit 1 holds the timer-3 request, reset 0.
// RL6: Secondary flag bit 0 holds the converter request, reset 0.
// RL7: Timer control bit 7 holds the timer-1 request, reset 0.
// RL8: Timer control bit 5 holds the timer-0 request, reset 0.
// RL9: Timer control bit 3 holds the second pin request, reset 0.
// RL10: Timer control bit 1 holds the first pin request, reset 0.
// RL11: Serial bit 1 is set when the transmitter reports frame completion.
// RL12: Serial bit 0 is set when the receiver reports frame completion.
// RL13: Software alone clears the serial transmit and receive flags.
// RL14: A request is taken only with flag, own enable and global enable all set.
// RL15: A flag is set by its event whether or not its source is enabled.
// RL16: Servicing clears most flags; disabled sources clear only by software.
// RL17: A set in the same cycle as a clear wins.
module iref_flags
    import iref_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Peripheral set pulses
    input wire logic ext_pin_irq_a_in,
    input wire logic ext_pin_irq_b_in,
    input wire logic ext_pin_irq_c_in,
    input wire logic timer0_set_in,
    input wire logic timer1_set_in,
    input wire logic timer3_set_in,
    input wire logic converter_set_in,
    input wire logic serial_tx_set_in,
    input wire logic serial_rx_set_in,
    // Core dispatch
    input wire logic irq_ack_in,
    output logic irq_req_out,
    output logic [2:0] irq_src_out,
    // Summary interrupt
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // Source index: 0 pin a, 1 timer0, 2 pin b, 3 timer1, 4 serial,
    // 5 timer3, 6 converter, 7 pin c

    logic [7:0] flag_q;
    logic [7:0] flag_d;
    logic serial_tx_q;
    logic serial_tx_d;
    logic serial_rx_q;
    logic serial_rx_d;
    logic [7:0] pen_q;
    logic [7:0] sen_q;
    logic [7:0] ist_q;
    logic [7:0] ist_d;
    logic [7:0] imk_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic irq_req_q;
    logic [2:0] irq_src_q;
    logic irq_q;

    wire wr_tcf = reg_wr_in && (reg_addr_in == IREF_TCF_ADDR);
    wire wr_scon = reg_wr_in && (reg_addr_in == IREF_SCON_ADDR);
    wire wr_sen = reg_wr_in && (reg_addr_in == IREF_SEN_ADDR);
    wire wr_sfl = reg_wr_in && (reg_addr_in == IREF_SFL_ADDR);
    wire wr_pen = reg_wr_in && (reg_addr_in == IREF_PEN_ADDR);
    wire wr_imk = reg_wr_in && (reg_addr_in == IREF_IMK_ADDR);
    wire rd_ist = reg_rd_in && (reg_addr_in == IREF_IST_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // Per-source set, write and enable mapping

    wire [7:0] set_vec = {ext_pin_irq_c_in, converter_set_in, timer3_set_in, 1'b0,
        timer1_set_in, ext_pin_irq_b_in, timer0_set_in, ext_pin_irq_a_in};
    wire [7:0] wr_vec = {wr_sfl, wr_sfl, wr_sfl, 1'b0, wr_tcf, wr_tcf, wr_tcf, wr_tcf};
    wire [7:0] wval_vec = {reg_wdata_in[IREF_EXT2_BIT], reg_wdata_in[IREF_CONV_BIT],
        reg_wdata_in[IREF_TMR3_BIT], 1'b0, reg_wdata_in[IREF_TMR1_BIT],
        reg_wdata_in[IREF_EXT1_BIT], reg_wdata_in[IREF_TMR0_BIT],
        reg_wdata_in[IREF_EXT0_BIT]};
    wire [7:0] en_vec = {sen_q[IREF_EXT2_BIT], sen_q[IREF_CONV_BIT], sen_q[IREF_TMR3_BIT],
        pen_q[4], pen_q[3], pen_q[2], pen_q[1], pen_q[0]};
    wire serial_any = serial_tx_q | serial_rx_q;
    wire [7:0] pend_vec = {flag_q[7:5], serial_any, flag_q[3:0]} & en_vec
        & {8{pen_q[IREF_GEN_BIT]}}; // [RL14]
    wire [7:0] ack_vec = (irq_ack_in && irq_req_q) ? (8'h01 << irq_src_q) : 8'h00;

    genvar gi;
    generate
        for (gi = 0; gi < IREF_NUM_SRC; gi++) begin : g_flag
            always_comb begin
                flag_d[gi] = flag_q[gi];
                if (wr_vec[gi]) begin
                    flag_d[gi] = wval_vec[gi];
                end
                if (ack_vec[gi] && (gi != 4)) begin
                    flag_d[gi] = 1'b0; // [RL16]
                end
                if (set_vec[gi]) begin
                    flag_d[gi] = 1'b1; // [RL15] [RL17]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Serial flags: never cleared by service

    always_comb begin
        serial_tx_d = serial_tx_q;
        serial_rx_d = serial_rx_q;
        if (wr_scon) begin
            serial_tx_d = reg_wdata_in[IREF_TXD_BIT]; // [RL13]
            serial_rx_d = reg_wdata_in[IREF_RXD_BIT];
        end
        if (serial_tx_set_in) begin
            serial_tx_d = 1'b1; // [RL11] [RL17]
        end
        if (serial_rx_set_in) begin
            serial_rx_d = 1'b1; // [RL12] [RL17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Lowest index pending wins

    logic [2:0] sel_src;
    always_comb begin
        sel_src = 3'h0;
        for (int i = IREF_NUM_SRC - 1; i >= 0; i--) begin
            if (pend_vec[i]) begin
                sel_src = 3'(i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky status of flag rises, cleared by reading

    wire [7:0] raw_vec = {flag_q[7:5], serial_any, flag_q[3:0]};
    wire [7:0] raw_nxt = {flag_d[7:5], serial_tx_d | serial_rx_d, flag_d[3:0]};
    wire [7:0] rise_vec = raw_nxt & ~raw_vec;
    assign ist_d = (rd_ist ? 8'h00 : ist_q) | rise_vec;

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    wire [7:0] tcf_rd = {flag_q[3], 1'b0, flag_q[1], 1'b0, flag_q[2], 1'b0,
        flag_q[0], 1'b0};
    wire [7:0] scon_rd = {6'h00, serial_tx_q, serial_rx_q};
    wire [7:0] sfl_rd = {5'h00, flag_q[7], flag_q[5], flag_q[6]};
    always_comb begin
        case (reg_addr_in)
            IREF_TCF_ADDR: rdata_d = tcf_rd; // [RL7] [RL8] [RL9] [RL10]
            IREF_SCON_ADDR: rdata_d = scon_rd;
            IREF_SEN_ADDR: rdata_d = sen_q; // [RL1] [RL2] [RL3]
            IREF_SFL_ADDR: rdata_d = sfl_rd; // [RL4] [RL5] [RL6]
            IREF_PEN_ADDR: rdata_d = pen_q;
            IREF_IST_ADDR: rdata_d = ist_q;
            IREF_IMK_ADDR: rdata_d = imk_q;
            default: rdata_d = IREF_RST_BYTE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Flip-flops

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flag_q <= IREF_RST_BYTE;
            serial_tx_q <= 1'b0;
            serial_rx_q <= 1'b0;
            pen_q <= IREF_RST_BYTE;
            sen_q <= IREF_RST_BYTE; // [RL1] [RL2] [RL3]
            ist_q <= IREF_RST_BYTE;
            imk_q <= IREF_RST_BYTE;
            rdata_q <= IREF_RST_BYTE;
            irq_req_q <= 1'b0;
            irq_src_q <= 3'h0;
            irq_q <= 1'b0;
        end else if (clk_en_in) begin
            flag_q <= flag_d;
            flag_q[4] <= 1'b0;
            serial_tx_q <= serial_tx_d;
            serial_rx_q <= serial_rx_d;
            if (wr_pen) begin
                pen_q <= reg_wdata_in & IREF_PEN_MASK;
            end
            if (wr_sen) begin
                sen_q <= reg_wdata_in & IREF_SEN_MASK;
            end
            if (wr_imk) begin
                imk_q <= reg_wdata_in;
            end
            ist_q <= ist_d;
            if (reg_rd_in) begin
                rdata_q <= rdata_d;
            end else begin
                rdata_q <= IREF_RST_BYTE;
            end
            irq_req_q <= |(pend_vec & ~ack_vec); // [RL14]
            irq_src_q <= sel_src;
            irq_q <= |(ist_d & imk_q);
        end
    end

    assign reg_rdata_out = rdata_q;
    assign irq_req_out = irq_req_q;
    assign irq_src_out = irq_src_q;
    assign irq_out = irq_q;

endmodule
`default_nettype wire

// ### rtl/iref_pkg.sv
/*
 * Constants for the interrupt enable and request-flag register block.
 * Assumes an 8-bit register port with 8-bit addresses, one clock, active-low reset.
 */
`default_nettype none
package iref_pkg;
    // Register addresses
    localparam logic [7:0] IREF_TCF_ADDR = 8'h88;
    localparam logic [7:0] IREF_SCON_ADDR = 8'h98;
    localparam logic [7:0] IREF_SEN_ADDR = 8'h9A;
    localparam logic [7:0] IREF_SFL_ADDR = 8'hBF;
    localparam logic [7:0] IREF_PEN_ADDR = 8'hA8;
    localparam logic [7:0] IREF_IST_ADDR = 8'hC0;
    localparam logic [7:0] IREF_IMK_ADDR = 8'hC1;
    // Field positions
    localparam int IREF_EXT2_BIT = 2;
    localparam int IREF_TMR3_BIT = 1;
    localparam int IREF_CONV_BIT = 0;
    localparam int IREF_TMR1_BIT = 7;
    localparam int IREF_TMR0_BIT = 5;
    localparam int IREF_EXT1_BIT = 3;
    localparam int IREF_EXT0_BIT = 1;
    localparam int IREF_TXD_BIT = 1;
    localparam int IREF_RXD_BIT = 0;
    localparam int IREF_GEN_BIT = 7;
    // Writable masks
    localparam logic [7:0] IREF_TCF_FLAGS = 8'hAA;
    localparam logic [7:0] IREF_SCON_FLAGS = 8'h03;
    localparam logic [7:0] IREF_SEN_MASK = 8'h07;
    localparam logic [7:0] IREF_SFL_MASK = 8'h07;
    localparam logic [7:0] IREF_PEN_MASK = 8'h9F;
    // Reset values and source count
    localparam logic [7:0] IREF_RST_BYTE = 8'h00;
    localparam logic [7:0] IREF_NO_SRC = 8'hFF;
    localparam int IREF_NUM_SRC = 8;
endpackage
`default_nettype wire

// ### tb/iref_flags_properties.sv
/* Port-level properties of the flag block.
   Assumes one clock and an active-low asynchronous reset. */
`default_nettype none
module iref_flags_checker import iref_pkg::*; (
    // Clock, reset and register port
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic clk_en_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Events and dispatch
    input wire logic timer1_set_in,
    input wire logic converter_set_in,
    input wire logic serial_tx_set_in,
    input wire logic serial_rx_set_in,
    input wire logic irq_ack_in,
    input wire logic irq_req_out,
    input wire logic [2:0] irq_src_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in || !clk_en_in);
    sequence s_rd(logic [7:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    property p_sen_resv; s_rd(IREF_SEN_ADDR) |=> reg_rdata_out[7:3] == 5'h00; endproperty
    a_sen_resv: assert property (p_sen_resv) else $error("enable spare bits");
    property p_sfl_resv; s_rd(IREF_SFL_ADDR) |=> reg_rdata_out[7:3] == 5'h00; endproperty
    a_sfl_resv: assert property (p_sfl_resv) else $error("flag spare bits");
    property p_tx_set; serial_tx_set_in ##1 s_rd(IREF_SCON_ADDR) |=> reg_rdata_out[1]; endproperty
    a_tx_set: assert property (p_tx_set) else $error("tx flag not set");
    property p_rx_win; serial_rx_set_in ##1 s_rd(IREF_SCON_ADDR) |=> reg_rdata_out[0]; endproperty
    a_rx_win: assert property (p_rx_win) else $error("rx flag lost");
    property p_t1_set; timer1_set_in ##1 s_rd(IREF_TCF_ADDR) |=> reg_rdata_out[7]; endproperty
    a_t1_set: assert property (p_t1_set) else $error("timer1 flag not set");
    property p_conv_set; converter_set_in ##1 s_rd(IREF_SFL_ADDR) |=> reg_rdata_out[0]; endproperty
    a_conv_set: assert property (p_conv_set) else $error("conv flag not set");
    property p_gen_off;
        reg_wr_in && reg_addr_in == IREF_PEN_ADDR && !reg_wdata_in[7] ##1 !reg_wr_in
            |=> !irq_req_out;
    endproperty
    a_gen_off: assert property (p_gen_off) else $error("request while off");
    property p_ack_clr;
        irq_ack_in && !reg_wr_in && irq_src_out == 3'h6 && !converter_set_in
            ##1 !converter_set_in ##0 s_rd(IREF_SFL_ADDR) |=> !reg_rdata_out[0];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("ack kept flag");
endmodule
////////////////////////////////////////
bind iref_flags iref_flags_checker chk_i (.*);
`default_nettype wire

// ### tb/iref_flags_test.sv
/* Self-checking bench for the flag block.
   Assumes the package, design, model and checker are compiled first. */
`default_nettype none
module iref_flags_test import iref_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_in = 0, rst_b_in = 0, clk_en_in = 1, reg_wr_in = 0, reg_rd_in = 0;
    logic irq_ack_in = 0, irq_req_out, irq_out, ext_pin_irq_a_in, ext_pin_irq_b_in;
    logic ext_pin_irq_c_in, timer0_set_in, timer1_set_in, timer3_set_in, converter_set_in;
    logic serial_tx_set_in, serial_rx_set_in;
    logic [2:0] irq_src_out;
    logic [7:0] reg_addr_in = 0, reg_wdata_in = 0, reg_rdata_out, d;
    logic [8:0] fire = 0, sets;
    logic [15:0] e;
    int mismatches = 0, check_count = 0;
    logic [7:0] ra [3] = '{IREF_TCF_ADDR, IREF_SCON_ADDR, IREF_SFL_ADDR};
    logic [15:0] loc [9] = '{16'h9801, 16'h9802, 16'hBF01, 16'hBF02, 16'h8880, 16'h8820,
        16'hBF04, 16'h8808, 16'h8802};
    assign {ext_pin_irq_a_in, ext_pin_irq_b_in, ext_pin_irq_c_in, timer0_set_in, timer1_set_in,
        timer3_set_in, converter_set_in, serial_tx_set_in, serial_rx_set_in} = sets;
    always #25 ref_clk_in = ~ref_clk_in;
    iref_flags DUT (.*);
    iref_periph_model peer (.clk_in(ref_clk_in), .rst_b_in(rst_b_in), .fire_in(fire),
        .set_out(sets));
    ////////////////////////////////////////
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
            mismatches++;
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] v);
        reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1;
        @(posedge ref_clk_in);
        reg_wr_in <= 0;
        #1;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        reg_addr_in <= a;
        reg_rd_in <= 1;
        @(posedge ref_clk_in);
        reg_rd_in <= 0;
        #1 chk(reg_rdata_out, exp);
    endtask
    task automatic pulse(int i);
        fire <= 9'h001 << i;
        @(posedge ref_clk_in);
        fire <= 0;
        @(posedge ref_clk_in);
        #1;
    endtask
    task automatic step(logic ack);
        irq_ack_in <= ack;
        repeat (4) @(posedge ref_clk_in);
        irq_ack_in <= 0;
        #1;
    endtask
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(2));
        repeat (10) @(posedge ref_clk_in);
        rst_b_in <= 1;
        @(posedge ref_clk_in);
        #1;
        foreach (ra[j]) rd(ra[j], 8'h00);
        rd(IREF_SEN_ADDR, 8'h00);
        rd(8'h00, 8'h00);
        repeat (6) begin
            d = 8'($urandom);
            wr(IREF_SEN_ADDR, d);
            rd(IREF_SEN_ADDR, d & 8'h07);
        end
        wr(IREF_SEN_ADDR, 8'h00);
        $display("Register test done");
        for (int i = 0; i < 9; i++) begin
            foreach (ra[j]) wr(ra[j], 8'h00);
            pulse(i);
            e = loc[i];
            rd(e[15:8], e[7:0]);
            foreach (ra[j]) if (ra[j] != e[15:8]) rd(ra[j], 8'h00);
        end
        fork
            pulse(0);
            #51 wr(IREF_SCON_ADDR, 8'h00);
        join
        rd(IREF_SCON_ADDR, 8'h01);
        $display("Flag test done");
        rd(IREF_IST_ADDR, 8'hFF);
        wr(IREF_IMK_ADDR, 8'h40);
        wr(IREF_SEN_ADDR, 8'h01);
        wr(IREF_PEN_ADDR, 8'h80);
        pulse(2);
        step(0);
        chk(irq_out, 1);
        chk({irq_req_out, irq_src_out}, 8'h0E);
        step(1);
        rd(IREF_SFL_ADDR, 8'h00);
        rd(IREF_IST_ADDR, 8'h40);
        wr(IREF_IMK_ADDR, 8'h00);
        pulse(2);
        step(0);
        chk(irq_out, 0);
        wr(IREF_PEN_ADDR, 8'h00);
        step(0);
        chk(irq_req_out, 0);
        wr(IREF_PEN_ADDR, 8'h90);
        pulse(1);
        step(0);
        chk(irq_src_out, 8'h04);
        step(1);
        rd(IREF_SCON_ADDR, 8'h03);
        $display("Interrupt test done");
        // Frozen clock enable drops a set pulse
        wr(IREF_TCF_ADDR, 8'h00);
        clk_en_in <= 0;
        pulse(5);
        clk_en_in <= 1;
        rd(IREF_TCF_ADDR, 8'h00);
        // Reset in mid-run clears the request and the SCON, SEN and SFL registers
        rst_b_in <= 0;
        repeat (2) @(posedge ref_clk_in);
        rst_b_in <= 1;
        @(posedge ref_clk_in);
        #1 chk(irq_req_out, 0);
        rd(IREF_SCON_ADDR, 8'h00);
        rd(IREF_SEN_ADDR, 8'h00);
        rd(IREF_SFL_ADDR, 8'h00);
        $display("Enable and reset test done");
        test_done();
    end
    initial begin
        #100000;
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire

// ### tb/iref_periph_model.sv
/* Peripheral stand-in: turns bench requests into set pulses.
   Assumes requests rise just after a rising edge. */
`default_nettype none
module iref_periph_model (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic [8:0] fire_in,
    output logic [8:0] set_out
);
    // One-cycle completion pulses
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) set_out <= 9'h000;
        else set_out <= fire_in & ~set_out;
    end
endmodule
`default_nettype wire
